// ===== src/psg_consts.vh
// Constants for the shared modulator, port and serial pin block
`ifndef PSG_CONSTS_VH
`define PSG_CONSTS_VH

// ==========================================================
// Pin count and positions of the serial roles
`define PSG_NUM_PINS 5
`define PSG_SEL_W 10
`define PSG_PIN_SS 2
`define PSG_PIN_MISO 3
`define PSG_PIN_MOSI 4

// ==========================================================
// Function codes, two bits per pin
`define PSG_FUNC_PWM 2'h0
`define PSG_FUNC_GPIO 2'h1
`define PSG_FUNC_SPI 2'h2
`define PSG_FUNC_NONE 2'h3

// ==========================================================
// Reset values
`define PSG_SEL_ALL_PWM 10'h000
`define PSG_SEL_ALL_NONE 10'h3FF
`define PSG_DIR_RESET 5'h00
`define PSG_OUT_RESET 5'h00
`define PSG_PULL_RESET 5'h1F
`define PSG_SS_IDLE 1'h1

`endif

// ===== src/psg_pin_sync.v
// Three-stage input synchroniser with agreement filter for pad inputs
`timescale 1ns/1ps

module psg_pin_sync #(
    parameter WIDTH = 5,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}}
) (
    input wire clock,
    input wire rst_n,
    input wire [WIDTH-1:0] asyncIn,
    output reg [WIDTH-1:0] syncOut
);

reg [WIDTH-1:0] stage1;
reg [WIDTH-1:0] stage2;
reg [WIDTH-1:0] stage3;

genvar i;
generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
        always @(posedge clock) begin
            if (!rst_n) begin
                stage1[i] <= RESET_VAL[i];
                stage2[i] <= RESET_VAL[i];
                stage3[i] <= RESET_VAL[i];
                syncOut[i] <= RESET_VAL[i];
            end else begin
                stage1[i] <= asyncIn[i];
                stage2[i] <= stage1[i];
                stage3[i] <= stage2[i];
                // Only a level seen on two late stages counts
                if (stage2[i] == stage3[i]) begin
                    syncOut[i] <= stage3[i];
                end
            end
        end
    end
endgenerate

endmodule // psg_pin_sync

// ===== src/psg_pin_share.v
// Pin sharing of five pads between modulator outputs, port bits and serial lines
`timescale 1ns/1ps
`include "psg_consts.vh"

module psg_pin_share (
    input wire clock,
    input wire rst_n,
    input wire variantFull,
    input wire funcSelWr,
    input wire [`PSG_SEL_W-1:0] funcSelData,
    input wire gpioDirWr,
    input wire [`PSG_NUM_PINS-1:0] gpioDirMask,
    input wire [`PSG_NUM_PINS-1:0] gpioDirData,
    input wire [`PSG_NUM_PINS-1:0] gpioOutData,
    input wire [`PSG_NUM_PINS-1:0] modbankAOut,
    input wire spiMasterMode,
    input wire spiSlaveTxBit,
    input wire spiMasterTxBit,
    input wire [`PSG_NUM_PINS-1:0] pinIn,
    output reg [`PSG_NUM_PINS-1:0] pinOut,
    output reg [`PSG_NUM_PINS-1:0] pinOe,
    output reg [`PSG_NUM_PINS-1:0] pinPullUp,
    output reg [`PSG_SEL_W-1:0] funcSel,
    output reg [`PSG_NUM_PINS-1:0] gpioDir,
    output wire [`PSG_NUM_PINS-1:0] gpioIn,
    output reg spiSlaveSelected,
    output reg spiRxEnable,
    output reg spiMasterInBit,
    output reg spiSlaveInBit
);

// Reset level of the pad data, one bit per pin
localparam [`PSG_NUM_PINS-1:0] OUT_RST = `PSG_OUT_RESET;

// ==========================================================
// Function decode
// Serial code on pins without a serial role means no function
function [1:0] effFunc;
    input [`PSG_SEL_W-1:0] sel;
    input integer idx;
    reg [1:0] code;
    begin
        code = sel[2*idx +: 2];
        if (code == `PSG_FUNC_SPI && idx < `PSG_PIN_SS) begin
            effFunc = `PSG_FUNC_NONE;
        end else begin
            effFunc = code;
        end
    end
endfunction

// ==========================================================
// Pad input synchronisation
wire [`PSG_NUM_PINS-1:0] pinSync;

psg_pin_sync #(
    .WIDTH(`PSG_NUM_PINS),
    .RESET_VAL(`PSG_PULL_RESET)
) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .asyncIn(pinIn),
    .syncOut(pinSync)
);

assign gpioIn = pinSync;

// ==========================================================
// Function select and port direction
// Default is applied one edge after release, so the strap is not
// loaded by the reset branch itself
reg defaultPending;

always @(posedge clock) begin
    if (!rst_n) begin
        funcSel <= `PSG_SEL_ALL_NONE;
        defaultPending <= 1'b1;
    end else if (defaultPending) begin
        defaultPending <= 1'b0;
        if (variantFull) begin
            funcSel <= `PSG_SEL_ALL_PWM;
        end else begin
            funcSel <= `PSG_SEL_ALL_NONE;
        end
    end else if (funcSelWr) begin
        funcSel <= funcSelData;
    end
end

always @(posedge clock) begin
    if (!rst_n) begin
        gpioDir <= `PSG_DIR_RESET;
    end else if (gpioDirWr) begin
        gpioDir <= (gpioDir & ~gpioDirMask) | (gpioDirData & gpioDirMask);
    end
end

// ==========================================================
// Serial slave select
wire ssFuncOn = (effFunc(funcSel, `PSG_PIN_SS) == `PSG_FUNC_SPI);
wire ssAsserted = ssFuncOn && (pinSync[`PSG_PIN_SS] == 1'b0);
wire slaveActive = !spiMasterMode && ssAsserted;

always @(posedge clock) begin
    if (!rst_n) begin
        spiSlaveSelected <= 1'b0;
        spiRxEnable <= 1'b0;
        spiMasterInBit <= 1'b0;
        spiSlaveInBit <= 1'b0;
    end else begin
        spiSlaveSelected <= ssAsserted;
        spiRxEnable <= slaveActive;
        // Receive paths steered by role
        spiMasterInBit <= spiMasterMode ? pinSync[`PSG_PIN_MISO] : 1'b0;
        spiSlaveInBit <= slaveActive ? pinSync[`PSG_PIN_MOSI] : 1'b0;
    end
end

// ==========================================================
// Per-pin drive
genvar p;
generate
    for (p = 0; p < `PSG_NUM_PINS; p = p + 1) begin : g_pin
        reg nextOut;
        reg nextOe;

        always @* begin
            nextOut = 1'b0;
            nextOe = 1'b0;
            case (effFunc(funcSel, p))
                `PSG_FUNC_PWM: begin
                    nextOut = modbankAOut[p];
                    nextOe = 1'b1;
                end
                `PSG_FUNC_GPIO: begin
                    nextOut = gpioOutData[p];
                    nextOe = gpioDir[p];
                end
                `PSG_FUNC_SPI: begin
                    if (p == `PSG_PIN_MISO) begin
                        // Fixed one-cycle latency keeps the core's half-clock lead
                        nextOut = spiSlaveTxBit;
                        nextOe = slaveActive;
                    end else if (p == `PSG_PIN_MOSI) begin
                        nextOut = spiMasterTxBit;
                        nextOe = spiMasterMode;
                    end else begin
                        nextOut = 1'b0;
                        nextOe = 1'b0;
                    end
                end
                default: begin
                    nextOut = 1'b0;
                    nextOe = 1'b0;
                end
            endcase
        end

        always @(posedge clock) begin
            if (!rst_n) begin
                pinOut[p] <= OUT_RST[p];
                pinOe[p] <= 1'b0;
                pinPullUp[p] <= 1'b1;
            end else begin
                pinOut[p] <= nextOut;
                pinOe[p] <= nextOe;
                // Pull-up only while the pad floats, saves current when driven
                pinPullUp[p] <= !nextOe;
            end
        end
    end
endgenerate

endmodule // psg_pin_share

// ===== testbench/psg_pin_share_checker.sv
// Assertion checker for the shared pin block
`timescale 1ns/1ps
`include "psg_consts.vh"
module psg_checker (
    input wire clock,
    input wire rst_n,
    input wire variantFull,
    input wire gpioDirWr,
    input wire [4:0] gpioDirMask,
    input wire [4:0] gpioDirData,
    input wire [4:0] gpioOutData,
    input wire [4:0] modbankAOut,
    input wire spiMasterMode,
    input wire spiMasterTxBit,
    input wire [4:0] pinOut,
    input wire [4:0] pinOe,
    input wire [4:0] pinPullUp,
    input wire [9:0] funcSel,
    input wire [4:0] gpioDir,
    input wire spiSlaveSelected
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // Serial role steps
    sequence sSlaveIdle;
        funcSel[7:6] == `PSG_FUNC_SPI && !spiMasterMode && !spiSlaveSelected;
    endsequence
    sequence sMasterOut;
        funcSel[9:8] == `PSG_FUNC_SPI && spiMasterMode;
    endsequence
    reset_pads_idle_a: assert property (
        $rose(rst_n) |-> pinOe == 5'h00 && pinPullUp == 5'h1F) else $error("pad live in reset");
    full_default_pwm_a: assert property (
        $rose(rst_n) && variantFull |=> funcSel == 10'h000) else $error("bad full default");
    modbank_drive_a: assert property (
        funcSel[1:0] == `PSG_FUNC_PWM |=> pinOe[0] && pinOut[0] == $past(modbankAOut[0]))
        else $error("modulator not on pin");
    port_dir_drive_a: assert property (
        funcSel[3:2] == `PSG_FUNC_GPIO |=> pinOe[1] == $past(gpioDir[1])
        && (!pinOe[1] || pinOut[1] == $past(gpioOutData[1]))) else $error("port pin wrong");
    dir_mask_write_a: assert property (
        gpioDirWr |=> gpioDir == (($past(gpioDir) & ~$past(gpioDirMask))
        | ($past(gpioDirData) & $past(gpioDirMask)))) else $error("direction write wrong");
    miso_release_a: assert property (
        sSlaveIdle [*2] |-> !pinOe[3]) else $error("unselected slave drives");
    mosi_master_a: assert property (
        sMasterOut |=> pinOe[4] && pinOut[4] == $past(spiMasterTxBit))
        else $error("master out not driven");
    select_undriven_a: assert property (
        funcSel[5:4] == `PSG_FUNC_SPI |=> !pinOe[2]) else $error("select pin driven");
endmodule // psg_checker
bind psg_pin_share psg_checker chk (.*);

// ===== testbench/psg_peer_model.sv
// Board and serial peer model resolving the five shared pads
`timescale 1ns/1ps
module psg_peer_model (
    input wire clock,
    input wire [4:0] pinOut,
    input wire [4:0] pinOe,
    input wire [4:0] pinPullUp,
    input wire [4:0] peerOe,
    input wire [4:0] peerVal,
    output wire [4:0] pinIn
);
    logic [4:0] last = 5'h1F;
    always @(posedge clock) begin
        last <= pinIn;
    end
    // Released pad floats: pull-up wins, else shows a changing level
    assign pinIn = (pinOe & pinOut) | (~pinOe & peerOe & peerVal)
        | (~pinOe & ~peerOe & (pinPullUp | ~last));
endmodule // psg_peer_model

// ===== testbench/test_pwm_spi_gpio_pin_share.sv
// Self-checking bench for the shared pin block
`timescale 1ns/1ps
module test_pwm_spi_gpio_pin_share;
    logic clock = 0, rst_n = 0, variantFull = 1, funcSelWr = 0, gpioDirWr = 0;
    logic spiMasterMode = 0, spiSlaveTxBit = 0, spiMasterTxBit = 0;
    logic [9:0] funcSelData = 10'h000;
    logic [4:0] gpioDirMask = 5'h00, gpioDirData = 5'h00, gpioOutData = 5'h00;
    logic [4:0] modbankAOut = 5'h00, peerOe = 5'h00, peerVal = 5'h00;
    wire [4:0] pinIn, pinOut, pinOe, pinPullUp, gpioDir, gpioIn;
    wire [9:0] funcSel;
    wire spiSlaveSelected, spiRxEnable, spiMasterInBit, spiSlaveInBit;
    int mismatches = 0, n_checks = 0;
    psg_pin_share dut (.*);
    psg_peer_model peer (.*);
    initial begin
        forever #10 clock = ~clock;
    end
    task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic do_reset(input logic full);
        @(posedge clock);
        rst_n <= 0;
        variantFull <= full;
        repeat (3) @(posedge clock);
        rst_n <= 1;
        #1;
        check("oe", pinOe, 0);
        check("pull", pinPullUp, 10'h01F);
        wait_n(3);
        check("sel", funcSel, full ? 10'h000 : 10'h3FF);
        check("oe", pinOe, full ? 10'h01F : 10'h000);
        $display("reset test done");
    endtask
    task automatic set_func(input logic [9:0] d);
        @(posedge clock);
        funcSelWr <= 1;
        funcSelData <= d;
        @(posedge clock);
        funcSelWr <= 0;
    endtask
    // ==========================================
    // Scenarios
    task automatic test_pwm;
        @(posedge clock);
        modbankAOut <= 5'h15;
        wait_n(2);
        check("pwm out", pinOut, 10'h015);
        $display("modulator test done");
    endtask
    task automatic test_port;
        set_func(10'h155);
        gpioDirWr <= 1;
        gpioDirMask <= 5'h05;
        gpioDirData <= 5'h1F;
        gpioOutData <= 5'h1F;
        @(posedge clock);
        gpioDirWr <= 0;
        peerOe <= 5'h02;
        wait_n(8);
        check("dir", gpioDir, 10'h005);
        check("oe", pinOe, 10'h005);
        check("in", gpioIn, 10'h01D);
        check("pull port", pinPullUp, 10'h01A);
        $display("port test done");
    endtask
    task automatic test_serial;
        set_func(10'h2A5);
        spiSlaveTxBit <= 1;
        peerOe <= 5'h04;
        peerVal <= 5'h04;
        wait_n(8);
        check("oe idle", pinOe, 10'h001);
        check("rx idle", spiRxEnable, 0);
        check("sel idle", spiSlaveSelected, 0);
        @(posedge clock);
        peerOe <= 5'h14;
        peerVal <= 5'h10;
        wait_n(8);
        check("rx", spiRxEnable, 1);
        check("oe slave", pinOe, 10'h009);
        check("slave out", pinOut[3], 1);
        check("slave in", spiSlaveInBit, 1);
        check("selected", spiSlaveSelected, 1);
        @(posedge clock);
        spiMasterMode <= 1;
        spiMasterTxBit <= 1;
        peerOe <= 5'h08;
        peerVal <= 5'h00;
        wait_n(8);
        check("oe master", pinOe, 10'h011);
        check("master out", pinOut[4], 1);
        check("master in", spiMasterInBit, 0);
        check("sel master", spiSlaveSelected, 0);
        $display("serial test done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        do_reset(1'b0);
        do_reset(1'b1);
        test_pwm();
        test_port();
        test_serial();
        wrap_up();
    end
    // Whole run is about 60 cycles; cut a hang well beyond that
    initial begin
        #20000;
        mismatches++;
        wrap_up();
    end
endmodule // test_pwm_spi_gpio_pin_share
